// ==== common/ladder_ref_consts.svh ====
// Purpose: Offsets, field positions, reset values for the reference ladder control
// Assumes: Register bus with byte-wide registers in the low bits of the data word
// Notes:   Offsets are local choices; bit positions follow the register layout
`ifndef LADDER_REF_CONSTS_SVH
`define LADDER_REF_CONSTS_SVH

`define LADDER_ADDR_W          4
`define LADDER_CONTROL_OFS     4'h0
`define LADDER_LEVEL_OFS       4'h1
`define LADDER_DATA_W          8
`define LADDER_CONTROL_RESET   8'h00
`define LADDER_LEVEL_RESET     8'h00
`define LADDER_CONTROL_MASK    8'hED
`define LADDER_LEVEL_MASK      8'h1F
`define LADDER_ENABLE_BIT      7
`define LADDER_LPS_BIT         6
`define LADDER_PIN_OE_BIT      5
`define LADDER_PSS_HI          3
`define LADDER_PSS_LO          2
`define LADDER_NSS_BIT         0
`define LADDER_CODE_HI         4
`define LADDER_TAPS            32

`endif

// ==== common/ladder_ref_pkg.sv ====
// Purpose: Types shared by the reference ladder control
// Assumes: Constants come from ladder_ref_consts.svh
// Notes:   Source codes match the two-bit positive source field
package ladder_ref_pkg;

    typedef enum logic [1:0] {
        POS_SUPPLY   = 2'h0,
        POS_EXT_REF  = 2'h1,
        POS_FIXED    = 2'h2,
        POS_RESERVED = 2'h3
    } pos_source_e;

    typedef struct packed {
        logic        ladder_enable;
        logic        low_power_side_select;
        logic        level_pin_output_enable;
        pos_source_e positive_source_select;
        logic        negative_source_select;
    } ladder_cfg_s;

    // Analog switch controls toward the ladder
    typedef struct packed {
        logic [2:0]  pos_sel_onehot;  // supply, external ref, fixed ref
        logic        neg_ext_sel;
        logic        neg_gnd_sel;
        logic        pos_connect;
        logic        neg_connect;
        logic [31:0] tap_sel;
        logic        pin_connect;
    } ladder_switch_s;

endpackage

// ==== design/dac_reference_control.sv ====
// Purpose: Register control for a 32-tap resistor-ladder voltage reference
// Assumes: Single clock; register port with read data one cycle after the strobe
// Notes:   Analog ladder is outside; this block drives its switch selects
// Operation
// - Control bit 7 enables the ladder, cleared disables it.
// - Control bit 6 picks low-power side: one keeps positive, zero keeps negative.
// - Control bit 5 connects level to the dedicated output pin.
// - Positive source field bits 3:2: supply, external, fixed reference; 11 reserved.
// - Control bit 0 selects external negative reference, else ground.
// - Level bits 4:0 pick one of 32 taps between the two sources.
// - Unused bits ignore writes and read as zero.
// - Any device reset clears both control registers.
// - Sleep wake-up leaves the control register unchanged.
// - Pin carrying the level overrides digital buffers and reads zero.
// - Low-power select set drops negative source, cleared drops positive.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
`include "ladder_ref_consts.svh"

module dac_reference_control #(
    parameter int ADDR_W = `LADDER_ADDR_W,
    parameter int DATA_W = 32
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         clk_en,
    input  wire logic [ADDR_W-1:0]            reg_addr,
    input  wire logic [DATA_W-1:0]            reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    output logic      [DATA_W-1:0]            reg_rdata,
    input  wire logic                         pin_digital_in,
    input  wire logic                         pin_digital_out,
    input  wire logic                         pin_digital_oe,
    output logic                              pin_read_value,
    output logic                              pin_driver_out,
    output logic                              pin_driver_oe,
    output logic                              pin_input_detect_en,
    output ladder_ref_pkg::ladder_switch_s    ladder_switch,
    output ladder_ref_pkg::ladder_cfg_s       ladder_cfg
);

    logic [7:0]        control_reg;
    logic [7:0]        level_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // Address decode
    wire hit_control = (reg_addr == `LADDER_CONTROL_OFS);
    wire hit_level   = (reg_addr == `LADDER_LEVEL_OFS);
    wire wr_control  = clk_en && reg_write && hit_control;
    wire wr_level    = clk_en && reg_write && hit_level;

    // unused bits masked
    // Masking on write keeps unused flops at zero so reads need no extra gating
    wire [7:0] control_next = reg_wdata[7:0] & `LADDER_CONTROL_MASK;
    wire [7:0] level_next   = reg_wdata[7:0] & `LADDER_LEVEL_MASK;

    // write edge update
    // Only reset or a write changes the registers; sleep and wake have no path here
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control_reg <= `LADDER_CONTROL_RESET;
            level_reg   <= `LADDER_LEVEL_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= control_next;
            end
            if (wr_level) begin
                level_reg <= level_next;
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        rdata_next = '0;
        if (hit_control) begin
            rdata_next[7:0] = control_reg;
        end else if (hit_level) begin
            rdata_next[7:0] = level_reg;
        end
    end

    // Read data held from the strobe until the next clk_en cycle, then cleared
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (clk_en) begin
            rdata_reg <= reg_read ? rdata_next : '0;
        end
    end
    assign reg_rdata = rdata_reg;

    // Field unpack
    // ladder enable
    assign ladder_cfg.ladder_enable           = control_reg[`LADDER_ENABLE_BIT];
    assign ladder_cfg.low_power_side_select   = control_reg[`LADDER_LPS_BIT];
    assign ladder_cfg.level_pin_output_enable = control_reg[`LADDER_PIN_OE_BIT];
    assign ladder_cfg.positive_source_select  =
        ladder_ref_pkg::pos_source_e'(control_reg[`LADDER_PSS_HI:`LADDER_PSS_LO]);
    assign ladder_cfg.negative_source_select  = control_reg[`LADDER_NSS_BIT];

    wire [4:0] level_code = level_reg[`LADDER_CODE_HI:0];

    // positive source decode
    // Reserved code connects nothing rather than shorting two sources
    assign ladder_switch.pos_sel_onehot[0] = (ladder_cfg.positive_source_select == ladder_ref_pkg::POS_SUPPLY);
    assign ladder_switch.pos_sel_onehot[1] = (ladder_cfg.positive_source_select == ladder_ref_pkg::POS_EXT_REF);
    assign ladder_switch.pos_sel_onehot[2] = (ladder_cfg.positive_source_select == ladder_ref_pkg::POS_FIXED);

    assign ladder_switch.neg_ext_sel = ladder_cfg.negative_source_select;
    assign ladder_switch.neg_gnd_sel = !ladder_cfg.negative_source_select;

    // side kept when off
    // Enabled ladder ties both ends; disabled keeps only the chosen side
    assign ladder_switch.pos_connect = ladder_cfg.ladder_enable || ladder_cfg.low_power_side_select;
    assign ladder_switch.neg_connect = ladder_cfg.ladder_enable || !ladder_cfg.low_power_side_select;

    // tap decode
    // One-hot tap select; code 0 sits at the negative end, 31 one step below positive
    genvar t;
    generate
        for (t = 0; t < `LADDER_TAPS; t++) begin : g_tap
            assign ladder_switch.tap_sel[t] = (level_code == 5'(t));
        end
    endgenerate

    assign ladder_switch.pin_connect = ladder_cfg.level_pin_output_enable;

    // pin override
    // While routed, digital driver and input detector are forced off and reads give zero
    assign pin_driver_oe       = pin_digital_oe && !ladder_cfg.level_pin_output_enable;
    assign pin_driver_out      = pin_digital_out && !ladder_cfg.level_pin_output_enable;
    assign pin_input_detect_en = !ladder_cfg.level_pin_output_enable;
    assign pin_read_value      = pin_digital_in && !ladder_cfg.level_pin_output_enable;

endmodule

// ==== tb/ladder_ref_sva.sv ====
// Purpose: Port checker for the reference ladder control
// Assumes: Control byte at 0x0, level byte at 0x1
// Notes:   Sleep is not modelled, so state only moves on write or reset
`timescale 1ns/100ps
module ladder_ref_sva #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32
) (
    input wire logic                           ref_clk,
    input wire logic                           rst,
    input wire logic                           clk_en,
    input wire logic [ADDR_W-1:0]              reg_addr,
    input wire logic [DATA_W-1:0]              reg_wdata,
    input wire logic                           reg_write,
    input wire logic                           reg_read,
    input wire logic [DATA_W-1:0]              reg_rdata,
    input wire logic                           pin_read_value,
    input wire logic                           pin_driver_oe,
    input wire logic                           pin_input_detect_en,
    input wire ladder_ref_pkg::ladder_switch_s ladder_switch,
    input wire ladder_ref_pkg::ladder_cfg_s    ladder_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Accepted strobes; clk_en low must freeze ladder_cfg
    sequence s_wr(a); clk_en && reg_write && reg_addr == a; endsequence
    sequence s_rd(a); clk_en && reg_read && reg_addr == a; endsequence
    property p_cfg; s_wr(0) |=> ladder_cfg == {$past(reg_wdata[7:5]), $past(reg_wdata[3:2]), $past(reg_wdata[0])};
    endproperty
    property p_keep; !(clk_en && reg_write) |=> $stable(ladder_cfg); endproperty
    property p_tap; s_wr(1) |=> ladder_switch.tap_sel == 32'h1 << $past(reg_wdata[4:0]); endproperty
    property p_rd; s_rd(0) |=> reg_rdata[DATA_W-1:8] == '0 && !reg_rdata[4] && !reg_rdata[1]; endproperty
    property p_pin; ladder_cfg.level_pin_output_enable |-> !pin_read_value && !pin_driver_oe && !pin_input_detect_en;
    endproperty
    property p_pss; ladder_cfg.positive_source_select == ladder_ref_pkg::POS_FIXED |->
        ladder_switch.pos_sel_onehot == 3'b100; endproperty
    property p_nss; ladder_cfg.negative_source_select |-> ladder_switch.neg_ext_sel && !ladder_switch.neg_gnd_sel;
    endproperty
    property p_lps; !ladder_cfg.ladder_enable |-> ladder_switch.pos_connect == ladder_cfg.low_power_side_select &&
        ladder_switch.neg_connect != ladder_cfg.low_power_side_select; endproperty
    a_cfg: assert property (p_cfg) else $error("control byte not stored");
    a_keep: assert property (p_keep) else $error("control moved without write");
    a_tap: assert property (p_tap) else $error("tap select wrong");
    a_rd: assert property (p_rd) else $error("unused control bits read nonzero");
    a_pin: assert property (p_pin) else $error("pin not overridden");
    a_pss: assert property (p_pss) else $error("fixed source not selected");
    a_nss: assert property (p_nss) else $error("negative source wrong");
    a_lps: assert property (p_lps) else $error("low power side wrong");
endmodule
bind dac_reference_control ladder_ref_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_ladder_ref_sva (.ref_clk, .rst,
    .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pin_read_value, .pin_driver_oe,
    .pin_input_detect_en, .ladder_switch, .ladder_cfg);

// ==== tb/tb_top.sv ====
// Purpose: Register, ladder and pin checks for the ladder control
// Assumes: Read data one cycle after the strobe
// Notes:   No sleep input, so wake-up is left to the checker
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic pin_digital_in = 1'b1, pin_digital_out = 1'b1, pin_digital_oe = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic pin_read_value, pin_driver_out, pin_driver_oe, pin_input_detect_en;
    ladder_ref_pkg::ladder_switch_s ladder_switch;
    ladder_ref_pkg::ladder_cfg_s ladder_cfg;
    logic [7:0] ctl [4] = '{8'h40, 8'h00, 8'h80, 8'h81};
    logic [3:0] sw [4] = '{4'h9, 4'h5, 4'hD, 4'hE};
    int fails = 0, n_tests = 0;
    always #2.5 ref_clk = ~ref_clk;
    dac_reference_control i_dac_reference_control (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .pin_digital_in, .pin_digital_out, .pin_digital_oe, .pin_read_value,
        .pin_driver_out, .pin_driver_oe, .pin_input_detect_en, .ladder_switch, .ladder_cfg);
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle strobes, released at the next edge
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, {24'h0, e});
    endtask
    task automatic end_sim;
        $display("Mismatches %0d in %0d checks", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #5000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'hED);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h1F);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        for (int i = 0; i < 32; i++) begin
            wr(4'h1, 8'(i));
            chk(ladder_switch.tap_sel, 32'h1 << i);
        end
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 8'(i << 2));
            chk(ladder_switch.pos_sel_onehot, (i == 3) ? 0 : 1 << i);
        end
        // Clamp cases: positive side, negative side, enabled both ends
        foreach (ctl[k]) begin
            wr(4'h0, ctl[k]);
            chk({ladder_switch.pos_connect, ladder_switch.neg_connect, ladder_switch.neg_ext_sel,
                ladder_switch.neg_gnd_sel}, sw[k]);
        end
        wr(4'h0, 8'h20);
        chk({pin_read_value, pin_driver_out, pin_driver_oe, pin_input_detect_en}, 0);
        chk(ladder_switch.pin_connect, 1);
        wr(4'h0, 8'h00);
        chk({pin_read_value, pin_driver_out, pin_driver_oe, pin_input_detect_en}, 4'hF);
        // Pin inputs low and high in turn, so the pass-through is really seen
        @(posedge ref_clk) {pin_digital_in, pin_digital_out, pin_digital_oe} <= 3'b010;
        #1 chk({pin_read_value, pin_driver_out, pin_driver_oe, pin_input_detect_en}, 4'h5);
        @(posedge ref_clk) clk_en <= 1'b0;
        wr(4'h1, 8'h05);
        @(posedge ref_clk) clk_en <= 1'b1;
        rd(4'h1, 8'h1F);
        // Software clamp to the negative end: ladder off, low side kept, code zero
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h01);
        chk({ladder_switch.pos_connect, ladder_switch.neg_connect, ladder_switch.neg_ext_sel,
            ladder_switch.tap_sel[0]}, 4'h7);
        // Software clamp to the positive end: fixed source, top code
        wr(4'h1, 8'h1F);
        wr(4'h0, 8'h48);
        chk({ladder_switch.pos_connect, ladder_switch.neg_connect, ladder_switch.pos_sel_onehot,
            ladder_switch.tap_sel[31]}, 6'h29);
        // Enable, then drop the enable as software would before sleep
        wr(4'h0, 8'hC8);
        wr(4'h0, 8'h48);
        chk(ladder_cfg.ladder_enable, 0);
        @(posedge ref_clk) rst <= 1'b1;
        @(posedge ref_clk) rst <= 1'b0;
        rd(4'h1, 8'h00);
        chk(ladder_cfg, 0);
        chk(ladder_switch.tap_sel, 32'h1);
        end_sim();
    end
endmodule
